/* File: verilog/uarab_top.sv */
// Asynchronous serial channel with APB registers, rate generator and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "uarab_consts.svh"
// Functional notes
// - Bit rate is count source divided by divider value plus one, then by 16.
// - Internal clock feeds divider undivided, divided by eight or by thirty-two.
// - External clock feeds the divider with the same divide-then-sixteen scheme.
// - Codes 100b/101b/110b select 7/8/9-bit async; 000b disables and resets channel.
// - Reading receive buffer upper byte clears parity, framing and receive-complete flags.
// - Framing and parity flags update when a character moves into the receive buffer.
module uarab_top import uarab_pkg::*; #(
	parameter int DIV_W = 8
) (
	input wire logic core_clk, // 100 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic rxd_pin, // Serial data in
	input wire logic ext_clk_pin, // External count clock
	output logic txd, // Serial data out
	output logic irq // Interrupt, level
);
	logic rst_q1, rst_sync_n;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_q1 <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_sync_n <= rst_q1;
		end
	end

	uarab_rate_if #(.DIV_W(DIV_W)) rif ();
	uarab_rate #(.DIV_W(DIV_W)) u_rate (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .ext_clk_pin(ext_clk_pin),
		.rif(rif));

	// Register state
	logic [6:0] mode, next_mode;
	logic [DIV_W-1:0] brg, next_brg;
	logic [1:0] clk_sel, next_clk_sel;
	logic tx_en, next_tx_en, rx_en, next_rx_en;
	logic [8:0] tb, next_tb;
	logic tb_full, next_tb_full;
	logic [8:0] rb, next_rb;
	logic rx_done, next_rx_done, frame_err, next_frame_err, par_err, next_par_err, oer, next_oer;
	logic [2:0] ist, next_ist, imask, next_imask;
	logic rb_stale, next_rb_stale;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;
	// Transmit state
	logic tx_busy, next_tx_busy, next_txd;
	logic [12:0] tx_sh, next_tx_sh;
	logic [3:0] tx_left, next_tx_left, tx_sub, next_tx_sub;
	// Receive state
	logic rxd_s1, rxd_s2;
	uarab_rx_e rx_st, next_rx_st;
	logic [3:0] rx_sub, next_rx_sub, rx_idx, next_rx_idx;
	logic [12:0] rx_bits, next_rx_bits;

	logic uart_on, tx_load, rx_xfer, rx_frame_bad, rx_par_bad, setup, done;
	logic [3:0] w, tx_len, rx_total;
	logic [8:0] rx_data;
	logic [9:0] idx;

	assign uart_on = mode[2:0] inside {UARAB_SMD_U7, UARAB_SMD_U8, UARAB_SMD_U9};
	assign w = (mode[2:0] == UARAB_SMD_U7) ? 4'd7 : (mode[2:0] == UARAB_SMD_U8) ? 4'd8 : 4'd9;
	assign tx_len = 4'(4'd2 + w + {3'b0, mode[`UARAB_MODE_PRYE]} + {3'b0, mode[`UARAB_MODE_STPS]});
	assign rx_total = 4'(tx_len - 4'd1);
	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign done = psel && penable && pready;
	assign rif.ckdir = mode[`UARAB_MODE_CKDIR];
	assign rif.clk_sel = clk_sel;
	assign rif.brg = brg;
	assign rif.run = uart_on && (tx_en || rx_en);

	// Frame, LSB first: start, data, optional parity, stop bits
	function automatic logic [12:0] uarab_frame(input logic [8:0] d, input logic [3:0] wd, input logic prye,
		input logic pry);
		logic [12:0] f;
		logic p;
		f = 13'h1FFF;
		f[0] = 1'b0;
		p = ~pry;
		for (int i = 0; i < 9; i++)
		begin
			if (i < wd)
			begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (prye)
			f[4'(wd + 4'd1)] = p;
		return f;
	endfunction

	// Transmitter: sixteen oversample ticks per bit
	always_comb
	begin
		tx_load = uart_on && tx_en && tb_full && !tx_busy;
		next_tx_busy = tx_busy;
		next_tx_sh = tx_sh;
		next_tx_left = tx_left;
		next_tx_sub = tx_sub;
		if (!uart_on)
		begin
			next_tx_busy = 1'b0;
			next_tx_sh = 13'h1FFF;
		end
		else if (tx_load)
		begin
			next_tx_sh = uarab_frame(tb, w, mode[`UARAB_MODE_PRYE], mode[`UARAB_MODE_PRY]);
			next_tx_left = tx_len;
			next_tx_sub = 4'h0;
			next_tx_busy = 1'b1;
		end
		else if (tx_busy && rif.os_tick)
		begin
			next_tx_sub = 4'(tx_sub + 4'h1);
			if (tx_sub == `UARAB_OS_LAST)
			begin
				next_tx_sh = {1'b1, tx_sh[12:1]};
				next_tx_left = 4'(tx_left - 4'h1);
				next_tx_busy = (tx_left != 4'h1);
			end
		end
		next_txd = next_tx_busy ? next_tx_sh[0] : 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tx_busy <= 1'b0;
			tx_sh <= 13'h1FFF;
			tx_left <= 4'h0;
			tx_sub <= 4'h0;
			txd <= 1'b1;
		end
		else
		begin
			tx_busy <= next_tx_busy;
			tx_sh <= next_tx_sh;
			tx_left <= next_tx_left;
			tx_sub <= next_tx_sub;
			txd <= next_txd;
		end
	end

	// Receiver: start checked at mid bit, then one sample per sixteen ticks
	always_comb
	begin
		logic p;
		logic [3:0] ps;
		p = ~mode[`UARAB_MODE_PRY];
		ps = 4'(w + {3'b0, mode[`UARAB_MODE_PRYE]});
		next_rx_st = rx_st;
		next_rx_sub = rx_sub;
		next_rx_idx = rx_idx;
		next_rx_bits = rx_bits;
		rx_xfer = 1'b0;
		if (!(uart_on && rx_en))
			next_rx_st = UARAB_RX_IDLE;
		else if (rif.os_tick)
		begin
			next_rx_sub = 4'(rx_sub + 4'h1);
			case (rx_st)
				UARAB_RX_IDLE:
				begin
					next_rx_sub = 4'h0;
					if (!rxd_s2)
						next_rx_st = UARAB_RX_START;
				end
				UARAB_RX_START:
				begin
					if (rx_sub == `UARAB_OS_MID)
					begin
						next_rx_st = rxd_s2 ? UARAB_RX_IDLE : UARAB_RX_DATA;
						next_rx_sub = 4'h0;
						next_rx_idx = 4'h0;
					end
				end
				UARAB_RX_DATA:
				begin
					if (rx_sub == `UARAB_OS_LAST)
					begin
						next_rx_bits[rx_idx] = rxd_s2;
						next_rx_idx = 4'(rx_idx + 4'h1);
						// Last index is the final stop bit
						if (rx_idx == 4'(rx_total - 4'h1))
						begin
							next_rx_st = UARAB_RX_IDLE;
							rx_xfer = 1'b1;
						end
					end
				end
				default: next_rx_st = UARAB_RX_IDLE;
			endcase
		end
		rx_data = 9'h000;
		for (int i = 0; i < 9; i++)
		begin
			if (i < w)
			begin
				rx_data[i] = next_rx_bits[i];
				p = p ^ next_rx_bits[i];
			end
		end
		rx_par_bad = mode[`UARAB_MODE_PRYE] && (p != next_rx_bits[w]);
		rx_frame_bad = !next_rx_bits[ps] || (mode[`UARAB_MODE_STPS] && !next_rx_bits[4'(ps + 4'd1)]);
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			rx_st <= UARAB_RX_IDLE;
			rx_sub <= 4'h0;
			rx_idx <= 4'h0;
			rx_bits <= 13'h1FFF;
		end
		else
		begin
			rxd_s1 <= rxd_pin;
			rxd_s2 <= rxd_s1;
			rx_st <= next_rx_st;
			rx_sub <= next_rx_sub;
			rx_idx <= next_rx_idx;
			rx_bits <= next_rx_bits;
		end
	end

	// Registers and APB slave; no wait states, hardware sets win over clears
	always_comb
	begin
		next_mode = mode;
		next_brg = brg;
		next_clk_sel = clk_sel;
		next_tx_en = tx_en;
		next_rx_en = rx_en;
		next_tb = tb;
		next_tb_full = tb_full;
		next_rb = rb;
		next_rx_done = rx_done;
		next_frame_err = frame_err;
		next_par_err = par_err;
		next_oer = oer;
		next_ist = ist;
		next_imask = imask;
		next_rb_stale = rb_stale;
		next_prdata = prdata;
		next_pready = pready;
		next_pslverr = pslverr;
		if (done && pwrite && pstrb[0])
		begin
			case (idx)
				`UARAB_IDX_MODE: next_mode = pwdata[6:0];
				`UARAB_IDX_RATE: next_brg = pwdata[DIV_W-1:0];
				`UARAB_IDX_CTL0: next_clk_sel = pwdata[1:0];
				`UARAB_IDX_CTL1:
				begin
					next_tx_en = pwdata[`UARAB_CTL1_TXEN];
					next_rx_en = pwdata[`UARAB_CTL1_RXEN];
				end
				`UARAB_IDX_TB:
				begin
					next_tb[7:0] = pwdata[7:0];
					next_tb_full = 1'b1;
				end
				`UARAB_IDX_IST: next_ist = ist & ~pwdata[2:0];
				`UARAB_IDX_IMASK: next_imask = pwdata[2:0];
				default: next_mode = mode;
			endcase
		end
		if (done && pwrite && pstrb[1] && idx == `UARAB_IDX_TB)
			next_tb[8] = pwdata[8];
		if (done && !pwrite && idx == `UARAB_IDX_RB && !rb_stale)
		begin
			next_rx_done = 1'b0;
			next_frame_err = 1'b0;
			next_par_err = 1'b0;
		end
		if (tx_load)
		begin
			next_tb_full = 1'b0;
			next_ist[`UARAB_IST_TXE] = 1'b1;
		end
		if (rx_xfer)
		begin
			next_rb = rx_data;
			next_frame_err = rx_frame_bad;
			next_par_err = rx_par_bad;
			next_oer = rx_done;
			next_rx_done = 1'b1;
			next_ist[`UARAB_IST_RXC] = 1'b1;
			if (rx_frame_bad || rx_par_bad || rx_done)
				next_ist[`UARAB_IST_RXERR] = 1'b1;
		end
		if (!uart_on)
		begin
			next_tb_full = 1'b0;
			next_rx_done = 1'b0;
			next_frame_err = 1'b0;
			next_par_err = 1'b0;
			next_oer = 1'b0;
		end
		if (setup)
			next_rb_stale = 1'b0;
		if (rx_xfer)
			next_rb_stale = 1'b1;
		if (done)
		begin
			next_pready = 1'b0;
			next_pslverr = 1'b0;
		end
		else if (setup)
		begin
			next_pready = 1'b1;
			next_pslverr = 1'b0;
			next_prdata = 32'h0000_0000;
			case (idx)
				`UARAB_IDX_MODE: next_prdata[6:0] = mode;
				`UARAB_IDX_RATE: next_prdata[DIV_W-1:0] = brg;
				`UARAB_IDX_TB: next_prdata = 32'h0000_0000;
				`UARAB_IDX_CTL0:
				begin
					next_prdata[1:0] = clk_sel;
					next_prdata[`UARAB_CTL0_TXEPT] = !tx_busy;
				end
				`UARAB_IDX_CTL1: next_prdata[3:0] = {rx_done, rx_en, !tb_full, tx_en};
				`UARAB_IDX_RB: next_prdata[15:0] = {oer || frame_err || par_err, par_err, frame_err, oer, 3'h0, rb};
				`UARAB_IDX_IST: next_prdata[2:0] = ist;
				`UARAB_IDX_IMASK: next_prdata[2:0] = imask;
				default: next_pslverr = 1'b1;
			endcase
		end
		next_irq = |(next_ist & next_imask);
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			mode <= `UARAB_MODE_RST;
			brg <= DIV_W'(`UARAB_RATE_RST);
			clk_sel <= 2'h0;
			tx_en <= 1'b0;
			rx_en <= 1'b0;
			tb <= 9'h000;
			tb_full <= 1'b0;
			rb <= 9'h000;
			rx_done <= 1'b0;
			frame_err <= 1'b0;
			par_err <= 1'b0;
			oer <= 1'b0;
			ist <= 3'h0;
			imask <= `UARAB_IMASK_RST;
			rb_stale <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			brg <= next_brg;
			clk_sel <= next_clk_sel;
			tx_en <= next_tx_en;
			rx_en <= next_rx_en;
			tb <= next_tb;
			tb_full <= next_tb_full;
			rb <= next_rb;
			rx_done <= next_rx_done;
			frame_err <= next_frame_err;
			par_err <= next_par_err;
			oer <= next_oer;
			ist <= next_ist;
			imask <= next_imask;
			rb_stale <= next_rb_stale;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
		end
	end

	AST_MODE_OFF: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(mode[2:0] == UARAB_SMD_OFF) |=> !tx_busy && !tb_full && rx_st == UARAB_RX_IDLE && !rx_done)
		else $error("disabled mode left channel state active");
	AST_RB_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(done && !pwrite && idx == `UARAB_IDX_RB && !rb_stale && !rx_xfer) |=> !rx_done && !frame_err && !par_err)
		else $error("receive buffer read did not clear flags");
	AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(!rx_xfer && uart_on && !(done && !pwrite)) |=> $stable(frame_err) && $stable(par_err))
		else $error("error flags moved without a buffer transfer");
	AST_TB_HI: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(done && pwrite && pstrb[1:0] == 2'b10 && idx == `UARAB_IDX_TB && !tb_full) |=> !tb_full)
		else $error("upper byte write queued a character");
	AST_TB_LO: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(done && pwrite && pstrb[0] && idx == `UARAB_IDX_TB && uart_on && !tx_busy && tx_en) |=> ##1 tx_busy)
		else $error("lower byte write did not start transmission");

	if (DIV_W < 1 || DIV_W > 16)
		$error("DIV_W out of range");
endmodule
`default_nettype wire

/* File: verilog/uarab_consts.svh */
// Register indices, field positions, reset values and timing counts
`ifndef UARAB_CONSTS_SVH
`define UARAB_CONSTS_SVH
`define UARAB_IDX_MODE 10'h0A0
`define UARAB_IDX_RATE 10'h0A1
`define UARAB_IDX_TB 10'h0A2
`define UARAB_IDX_CTL0 10'h0A4
`define UARAB_IDX_CTL1 10'h0A5
`define UARAB_IDX_RB 10'h0A6
`define UARAB_IDX_IST 10'h0A8
`define UARAB_IDX_IMASK 10'h0A9
`define UARAB_MODE_CKDIR 3
`define UARAB_MODE_STPS 4
`define UARAB_MODE_PRY 5
`define UARAB_MODE_PRYE 6
`define UARAB_CTL0_TXEPT 3
`define UARAB_CTL1_TXEN 0
`define UARAB_CTL1_TBEMPTY 1
`define UARAB_CTL1_RXEN 2
`define UARAB_CTL1_RXDONE 3
`define UARAB_RB_OVR 12
`define UARAB_RB_FRAME 13
`define UARAB_RB_PARITY 14
`define UARAB_RB_SUM 15
`define UARAB_IST_TXE 0
`define UARAB_IST_RXC 1
`define UARAB_IST_RXERR 2
`define UARAB_MODE_RST 7'h00
`define UARAB_RATE_RST 8'h00
`define UARAB_IMASK_RST 3'h0
`define UARAB_OS_LAST 4'hF
`define UARAB_OS_MID 4'h7
`define UARAB_PRE_DIV8 3'h7
`define UARAB_PRE_DIV32 5'h1F
`endif

/* File: verilog/uarab_pkg.sv */
// Types shared by the serial channel modules
package uarab_pkg;
	typedef enum logic [1:0] {UARAB_SRC_UNDIV = 2'b00, UARAB_SRC_DIV8 = 2'b01, UARAB_SRC_DIV32 = 2'b10} uarab_src_e;
	typedef enum logic [2:0] {UARAB_SMD_OFF = 3'b000, UARAB_SMD_U7 = 3'b100, UARAB_SMD_U8 = 3'b101,
		UARAB_SMD_U9 = 3'b110} uarab_smd_e;
	typedef enum logic [1:0] {UARAB_RX_IDLE = 2'b00, UARAB_RX_START = 2'b01, UARAB_RX_DATA = 2'b10} uarab_rx_e;
endpackage

/* File: verilog/uarab_rate_if.sv */
// Interface between channel control and the bit rate generator
`timescale 1ns/1ns
`default_nettype none
interface uarab_rate_if #(parameter int DIV_W = 8);
	logic ckdir;
	logic [1:0] clk_sel;
	logic [DIV_W-1:0] brg;
	logic run;
	logic os_tick;
	modport ctl (output ckdir, output clk_sel, output brg, output run, input os_tick);
	modport gen (input ckdir, input clk_sel, input brg, input run, output os_tick);
endinterface
`default_nettype wire

/* File: verilog/uarab_rate.sv */
// Bit rate generator: count source select, rate divider, 16x oversample tick
`timescale 1ns/1ns
`default_nettype none
`include "uarab_consts.svh"
module uarab_rate import uarab_pkg::*; #(
	parameter int DIV_W = 8
) (
	input wire logic core_clk, // System clock
	input wire logic rst_sync_n, // Synchronised reset
	input wire logic ext_clk_pin, // External count clock pin
	uarab_rate_if.gen rif // Rate control and tick
);
	logic [4:0] pre, next_pre;
	logic [DIV_W-1:0] div, next_div;
	logic tick, next_tick;
	logic ext_s1, ext_s2, ext_s3;
	logic src_tick;

	always_comb
	begin
		next_pre = 5'(pre + 5'h01);
		src_tick = 1'b0;
		if (rif.ckdir)
			src_tick = ext_s2 & ~ext_s3;
		else
		begin
			case (rif.clk_sel)
				UARAB_SRC_UNDIV: src_tick = 1'b1;
				UARAB_SRC_DIV8: src_tick = (pre[2:0] == `UARAB_PRE_DIV8);
				UARAB_SRC_DIV32: src_tick = (pre == `UARAB_PRE_DIV32);
				default: src_tick = 1'b0;
			endcase
		end
		next_div = div;
		next_tick = 1'b0;
		if (!rif.run)
			next_div = rif.brg;
		else if (src_tick)
		begin
			// Divide by brg+1; the 16x step is taken by the channel
			if (div == '0)
			begin
				next_div = rif.brg;
				next_tick = 1'b1;
			end
			else
				next_div = DIV_W'(div - 1'b1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pre <= 5'h00;
			div <= '0;
			tick <= 1'b0;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end
		else
		begin
			pre <= next_pre;
			div <= next_div;
			tick <= next_tick;
			ext_s1 <= ext_clk_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	assign rif.os_tick = tick;

	// Checker helpers: cycles since last tick, and whether config stayed undivided
	logic [DIV_W:0] gap;
	logic clean;
	logic undiv_run;
	assign undiv_run = rif.run && !rif.ckdir && rif.clk_sel == UARAB_SRC_UNDIV;
	always_ff @(posedge core_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			gap <= '0;
			clean <= 1'b0;
		end
		else
		begin
			gap <= tick ? '0 : (DIV_W+1)'(gap + 1'b1);
			clean <= undiv_run && $stable(rif.brg) && (clean || tick);
		end
	end
	AST_DIV_GAP: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(tick && clean && undiv_run && $stable(rif.brg)) |-> gap == {1'b0, rif.brg})
		else $error("rate divider period is not brg+1");
	AST_DIV8_SRC: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(rif.run && !rif.ckdir && rif.clk_sel == UARAB_SRC_DIV8 && pre[2:0] != `UARAB_PRE_DIV8)
		|=> div == $past(div))
		else $error("divide-by-8 source counted off its prescaler edge");
	AST_EXT_SRC: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
		(rif.run && rif.ckdir && !(ext_s2 && !ext_s3)) |=> div == $past(div) && !tick)
		else $error("external source counted without an external edge");

	if (DIV_W < 1 || DIV_W > 16)
		$error("DIV_W out of range");
endmodule
`default_nettype wire

/* File: test/uarab_remote.sv */
// Remote asynchronous serial device: frame sender and frame catcher
`timescale 1ns/1ns
`default_nettype none
module uarab_remote (
	input wire logic core_clk, // Bench clock
	input wire logic txd, // Line from the channel
	output logic rxd // Line to the channel
);
	initial rxd = 1'b1;
	// Start, nb bits LSB first, one stop; a bad stop is low only until past mid-bit
	task automatic send(input logic [8:0] d, input int nb, input int p, input logic bad);
		int i;
		@(posedge core_clk);
		rxd <= 1'b0;
		repeat (p) @(posedge core_clk);
		for (i = 0; i < nb; i++)
		begin
			rxd <= d[i];
			repeat (p) @(posedge core_clk);
		end
		rxd <= ~bad;
		repeat (bad ? 3 * p / 4 : p) @(posedge core_clk);
		rxd <= 1'b1;
		repeat (p) @(posedge core_clk);
	endtask
	// Bit 0 length measured; data must have bit 0 high and bit 1 low
	task automatic catch(input int p, input int nb, output logic [8:0] d, output int plen, output logic ok);
		int i;
		d = 9'h000;
		plen = 0;
		ok = 1'b0;
		for (i = 0; i < 8000 && !ok; i++)
		begin
			@(posedge core_clk);
			ok = (txd === 1'b0);
		end
		while (txd === 1'b0 && plen < 8000)
		begin
			plen++;
			@(posedge core_clk);
		end
		// Start bit width follows the tick phase; bit 0 is a full period
		plen = 0;
		d[0] = txd;
		while (txd === 1'b1 && plen < 8000)
		begin
			plen++;
			@(posedge core_clk);
		end
		repeat (p / 2) @(posedge core_clk);
		for (i = 1; i < nb; i++)
		begin
			d[i] = txd;
			repeat (p) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

/* File: test/uarab_top_tb_top.sv */
// Self-checking bench for the asynchronous serial channel
`timescale 1ns/1ns
`default_nettype none
`include "uarab_consts.svh"
module uarab_top_tb_top import uarab_pkg::*; ;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_clk_pin = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, rxd_pin, txd, irq, slv_err, ok;
	logic [1:0] ediv = 2'h0;
	logic [16:0] seed = 17'h14803;
	logic [8:0] d, got;
	int err_total = 0, samples_checked = 0, k, plen, p;
	logic [1:0] srcs [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
	logic exts [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	int ns [4] = '{3, 1, 0, 1};
	logic [2:0] codes [3] = '{UARAB_SMD_U7, UARAB_SMD_U8, UARAB_SMD_U9};
	int nbs [3] = '{7, 8, 9};
	uarab_top i_uarab_top (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd_pin(rxd_pin), .ext_clk_pin(ext_clk_pin), .txd(txd), .irq(irq));
	uarab_remote i_uarab_remote (.core_clk(core_clk), .txd(txd), .rxd(rxd_pin));
	always #5 core_clk = ~core_clk;
	// External count clock of 8 core cycles, phase free of the prescaler
	always @(posedge core_clk)
	begin
		ediv <= ediv + 2'h1;
		if (ediv == 2'h3)
			ext_clk_pin <= ~ext_clk_pin;
	end
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	function automatic int bit_len(input logic [1:0] src, input logic ext, input int n);
		int pre;
		pre = (ext || src == 2'b01) ? 8 : (src == 2'b10 ? 32 : 1);
		return (n + 1) * pre * 16;
	endfunction
	function automatic logic [8:0] keep(input logic [8:0] v, input int nb);
		return v & ((9'h001 << nb) - 9'h001);
	endfunction
	function automatic logic [8:0] even_frame(input logic [7:0] v);
		return {^v, v};
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang();
		err_total++;
		close_out();
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] wd, input logic [3:0] st);
		int i;
		ok = 1'b0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= wd;
		pstrb <= st;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 16 && !ok; i++)
		begin
			@(posedge core_clk);
			ok = (pready === 1'b1);
			rv = prdata;
			slv_err = pslverr;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!ok)
			hang();
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		apb(1'b1, a, v, 4'hF);
	endtask
	task automatic rd(input logic [9:0] a);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask
	task automatic cfg(input logic [31:0] mode, input logic [1:0] src, input int n);
		wr(`UARAB_IDX_CTL1, 32'h0);
		wr(`UARAB_IDX_MODE, mode);
		wr(`UARAB_IDX_CTL0, {30'h0, src});
		wr(`UARAB_IDX_RATE, 32'(n));
		wr(`UARAB_IDX_CTL1, 32'h5);
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge core_clk);
		chk("irq", {31'h0, irq}, {31'h0, v});
	endtask
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(`UARAB_IDX_MODE);
		chk("mode reset", rv, 32'h0);
		rd(`UARAB_IDX_RATE);
		chk("rate reset", rv, 32'h0);
		rd(10'h3FF);
		chk("unmapped err", {31'h0, slv_err}, 32'h1);
		chk("unmapped data", rv, 32'h0);
		$display("test reset done");
		for (k = 0; k < 4; k++)
		begin
			cfg({28'h0, exts[k], UARAB_SMD_U8}, srcs[k], ns[k]);
			p = bit_len(srcs[k], exts[k], ns[k]);
			seed = lfsr(seed);
			d = {1'b0, seed[7:2], 2'b01};
			apb(1'b1, `UARAB_IDX_TB, {23'h0, d}, 4'h1);
			i_uarab_remote.catch(p, 8, got, plen, ok);
			if (!ok)
				hang();
			chk("bit length", 32'(plen), 32'(p));
			chk("tx data", {23'h0, got}, {23'h0, d});
			repeat (2 * p) @(posedge core_clk);
		end
		$display("test rates done");
		cfg({29'h0, UARAB_SMD_U9}, 2'b00, 3);
		seed = lfsr(seed);
		d = {seed[9], seed[7:2], 2'b01};
		apb(1'b1, `UARAB_IDX_TB, {23'h0, d}, 4'h2);
		repeat (6) @(posedge core_clk);
		chk("no start on upper byte", {31'h0, txd}, 32'h1);
		apb(1'b1, `UARAB_IDX_TB, {23'h0, d}, 4'h1);
		i_uarab_remote.catch(64, 9, got, plen, ok);
		if (!ok)
			hang();
		chk("tx 9 bit", {23'h0, got}, {23'h0, d});
		repeat (128) @(posedge core_clk);
		rd(`UARAB_IDX_CTL0);
		chk("shifter empty", {31'h0, rv[`UARAB_CTL0_TXEPT]}, 32'h1);
		rd(`UARAB_IDX_IST);
		chk("tb moved", {31'h0, rv[`UARAB_IST_TXE]}, 32'h1);
		$display("test nine bit tx done");
		cfg({29'h0, UARAB_SMD_U8}, 2'b00, 3);
		wr(`UARAB_IDX_IMASK, 32'h4);
		wr(`UARAB_IDX_IST, 32'h7);
		seed = lfsr(seed);
		d = {1'b0, seed[7:0]};
		i_uarab_remote.send(d, 8, 64, 1'b1);
		rd(`UARAB_IDX_RB);
		chk("rb data", {23'h0, rv[8:0]}, {23'h0, d});
		chk("framing flag", {31'h0, rv[`UARAB_RB_FRAME]}, 32'h1);
		chk("error sum", {31'h0, rv[`UARAB_RB_SUM]}, 32'h1);
		irq_is(1'b1);
		wr(`UARAB_IDX_IMASK, 32'h0);
		irq_is(1'b0);
		wr(`UARAB_IDX_IMASK, 32'h4);
		irq_is(1'b1);
		rd(`UARAB_IDX_RB);
		chk("framing after read", {31'h0, rv[`UARAB_RB_FRAME]}, 32'h0);
		chk("parity after read", {31'h0, rv[`UARAB_RB_PARITY]}, 32'h0);
		rd(`UARAB_IDX_CTL1);
		chk("complete after read", {31'h0, rv[`UARAB_CTL1_RXDONE]}, 32'h0);
		wr(`UARAB_IDX_IST, 32'h7);
		irq_is(1'b0);
		$display("test rx error done");
		i_uarab_remote.send(9'h0A5, 8, 64, 1'b0);
		rd(`UARAB_IDX_CTL1);
		chk("complete set", {28'h0, rv[3:0]}, 32'hF);
		wr(`UARAB_IDX_CTL1, 32'h0);
		wr(`UARAB_IDX_MODE, 32'h0);
		rd(`UARAB_IDX_CTL1);
		chk("channel reset", {28'h0, rv[3:0]}, 32'h2);
		for (k = 0; k < 3; k++)
		begin
			cfg({29'h0, codes[k]}, 2'b00, 3);
			seed = lfsr(seed);
			d = seed[8:0];
			i_uarab_remote.send(d, nbs[k], 64, 1'b0);
			rd(`UARAB_IDX_RB);
			chk("rx data", {23'h0, rv[8:0]}, {23'h0, keep(d, nbs[k])});
			chk("rx flags", {28'h0, rv[15:12]}, 32'h0);
		end
		$display("test recovery done");
		// Even parity, two stop bits, 8-bit data
		cfg(32'h75, 2'b00, 3);
		seed = lfsr(seed);
		d = {1'b0, seed[7:2], 2'b01};
		apb(1'b1, `UARAB_IDX_TB, {23'h0, d}, 4'h1);
		i_uarab_remote.catch(64, 9, got, plen, ok);
		if (!ok)
			hang();
		chk("tx parity", {23'h0, got}, {23'h0, even_frame(d[7:0])});
		repeat (256) @(posedge core_clk);
		for (k = 0; k < 2; k++)
		begin
			seed = lfsr(seed);
			d = even_frame(seed[7:0]) ^ {k[0], 8'h00};
			i_uarab_remote.send(d, 9, 64, 1'b0);
			rd(`UARAB_IDX_RB);
			chk("rx parity data", {23'h0, rv[8:0]}, {23'h0, 1'b0, d[7:0]});
			chk("parity flag", {31'h0, rv[`UARAB_RB_PARITY]}, {31'h0, k[0]});
			chk("framing flag 2 stop", {31'h0, rv[`UARAB_RB_FRAME]}, 32'h0);
		end
		$display("test parity done");
		close_out();
	end
endmodule
`default_nettype wire
